// file: tb/plcc_ctrl_asserts.sv
// checker for the pulse-count controller
// assumes one clock domain with a synchronous active-high reset
module plcc_ctrl_asserts #(
	parameter int LATCH_CYC = plcc_pkg::LATCH_CYC,
	parameter int OFF_CYC   = plcc_pkg::OFF_CYC
) (
	// clock and reset
	input wire logic                                        clk,
	input wire logic                                        rst,
	// control pin
	input wire logic                                        ctrlPin,
	// outputs
	input wire logic                                        enabled,
	input wire plcc_pkg::plcc_regs_t                        regs,
	input wire plcc_pkg::plcc_pump_t                        pumpMode,
	input wire logic [plcc_pkg::CH_N-1:0][plcc_pkg::CODE_W-1:0] sinkCode,
	input wire logic [plcc_pkg::CH_N-1:0][plcc_pkg::CUR_W-1:0]  sinkCurrent,
	input wire logic [plcc_pkg::CH_N-1:0]                   usePumpOutput
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LAT_LO = LATCH_CYC - 10;
	localparam int OFF_LO = OFF_CYC - 10;
	localparam int OFF_HI = OFF_CYC + 10;
	int hiCnt;
	int loCnt;
	// run lengths of each pin level; slack of ten cycles covers the decoder pipeline
	always_ff @(posedge clk) begin
		hiCnt <= (rst || !ctrlPin) ? 0 : hiCnt + 1;
		loCnt <= (rst || ctrlPin) ? 0 : loCnt + 1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_rise; !ctrlPin ##1 ctrlPin; endsequence
	sequence s_dark; !enabled [*3]; endsequence
	chk_rise_enables: assert property (s_rise |-> ##[0:2] enabled)
		else $error("rise left device off");
	chk_latch_wait: assert property (enabled && $past(enabled) && $changed(regs) |-> hiCnt >= LAT_LO)
		else $error("registers moved before pause");
	chk_off_late: assert property (loCnt >= OFF_HI |-> !enabled)
		else $error("no shutdown after long low");
	chk_off_early: assert property ($fell(enabled) |-> loCnt >= OFF_LO)
		else $error("shutdown too early");
	chk_off_clears: assert property ($fell(enabled) |-> ##[0:1] regs == '0)
		else $error("shutdown kept state");
	chk_code_route: assert property (sinkCode[2] == regs.groupA && sinkCode[0] == regs.groupA && sinkCode[1] == regs.groupA
		&& sinkCode[3] == regs.chFour)
		else $error("code routed wrongly");
	chk_idle_pump: assert property (s_dark |-> pumpMode == plcc_pkg::PUMP_OFF && usePumpOutput == '0)
		else $error("pump active while off");
	chk_dark_current: assert property (s_dark |-> sinkCurrent == '0)
		else $error("current while off");
	chk_pump_start: assert property ($past(pumpMode) == plcc_pkg::PUMP_OFF && pumpMode != plcc_pkg::PUMP_OFF
		|-> pumpMode == plcc_pkg::PUMP_X15)
		else $error("pump did not start at low ratio");
	chk_pump_hold: assert property ($past(pumpMode) == plcc_pkg::PUMP_X2 && enabled
		|-> pumpMode == plcc_pkg::PUMP_X2)
		else $error("pump stepped down");
endmodule
bind plcc_ctrl plcc_ctrl_asserts #(.LATCH_CYC(LATCH_CYC), .OFF_CYC(OFF_CYC)) chk (.clk(clk), .rst(rst),
	.ctrlPin(ctrlPin), .enabled(enabled), .regs(regs),
	.pumpMode(pumpMode), .sinkCode(sinkCode), .sinkCurrent(sinkCurrent), .usePumpOutput(usePumpOutput));

// file: tb/plcc_ctrl_bench.sv
// self-checking bench for the pulse-count controller
// assumes the host model and the bound checker
module plcc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// shortened timeouts keep the run small; the decoder counts them the same way
	localparam int LATCH_TIMEOUT = 2000;
	logic                      clk;
	logic [plcc_pkg::CH_N-1:0][plcc_pkg::CUR_W-1:0] sinkCurrent;
	logic                      rst;
	logic                      ctrlPin;
	logic                      enabled;
	logic [plcc_pkg::CH_N-1:0] nearDropout;
	plcc_pkg::plcc_regs_t      regs;
	plcc_pkg::plcc_regs_t      expRegs;
	int                        fails;
	int                        checksDone;
	int                        seed;
	int                        n;
	int                        steps [7] = '{0, 34, 32, 40, 35, 3, 33};
	plcc_host #(.LATCH_CYC(LATCH_TIMEOUT)) host (.clk(clk), .ctrlPin(ctrlPin));
	plcc_ctrl #(.LATCH_CYC(LATCH_TIMEOUT), .OFF_CYC(LATCH_TIMEOUT)) DUT (.clk(clk), .rst(rst), .ctrlPin(ctrlPin),
		.nearDropout(nearDropout), .enabled(enabled),
		.regs(regs), .pumpMode(), .sinkCode(), .sinkCurrent(sinkCurrent), .usePumpOutput());
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// register image after one latched burst of n edges; wider counts change nothing
	function automatic plcc_pkg::plcc_regs_t apply(plcc_pkg::plcc_regs_t r, int n);
		if (n > 32 && n < 36) r.addr = 2'(n - 33);
		else if (n > 0 && n < 33) begin
			if (r.addr != plcc_pkg::ADDR_CH4) r.groupA = 5'(n);
			if (r.addr != plcc_pkg::ADDR_GRPA) r.chFour = 5'(n);
		end
		return r;
	endfunction
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// dropout senses wander so the pump and path logic see traffic
	always @(posedge clk)
		if (!rst && $unsigned($random(seed)) % 500 == 0) nearDropout <= 4'($random(seed));
	// data with no address, address changes, full-scale code, an ignored count of 40, then shutdown
	initial begin
		seed = 26128;
		rst = 1'b1;
		nearDropout = 4'h0;
		expRegs = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		steps[0] = 1 + ($unsigned($random(seed)) % 31);
		foreach (steps[i]) begin
			host.burst(steps[i]);
			expRegs = apply(expRegs, steps[i]);
			cmp(regs, expRegs);
		end
		cmp(12'(enabled), 12'h001);
		cmp(12'(sinkCurrent[0]), 12'h12C);
		cmp(12'(sinkCurrent[3]), 12'h002);
		host.park();
		n = 0;
		while (enabled === 1'b1 && n < 3 * LATCH_TIMEOUT) begin
			@(posedge clk);
			n++;
		end
		if (n == 3 * LATCH_TIMEOUT) fails++;
		repeat (2) @(posedge clk);
		cmp(regs, 12'h000);
		cmp(12'(enabled), 12'h000);
		final_report();
	end
endmodule

// file: tb/plcc_host.sv
// host model that drives the single control pin
// assumes a 100 MHz clk; the bench calls its tasks just after a rising edge
module plcc_host #(
	parameter int LATCH_CYC = plcc_pkg::LATCH_CYC
) (
	// clock
	input  wire logic clk,
	// control pin
	output logic      ctrlPin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ctrlPin = 1'b0;
	// low 30 cycles, high 5: the high pulse sits at the 50 ns minimum width
	task automatic burst(input int n);
		repeat (n) begin
			ctrlPin <= 1'b0;
			repeat (30) @(posedge clk);
			ctrlPin <= 1'b1;
			repeat (5) @(posedge clk);
		end
		// stay high past the pause so the count is taken
		repeat (LATCH_CYC + 20) @(posedge clk);
	endtask
	// drop the pin and leave it low
	task automatic park();
		ctrlPin <= 1'b0;
		@(posedge clk);
	endtask
endmodule

// file: verilog/plcc_ctrl.sv
// pulse-count decoder, level registers, pump mode and per-output supply path
// assumes ctrlPin is synchronous to clk; dropout senses come from analog comparators
module plcc_ctrl #(
	// timeouts in clk cycles; the defaults are the device figures, smaller values only shorten test runs
	parameter int LATCH_CYC = plcc_pkg::LATCH_CYC,
	parameter int OFF_CYC   = plcc_pkg::OFF_CYC
) (
	// clock and reset
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	// single-wire control pin
	input  wire logic                                  ctrlPin,
	// dropout senses, one per output
	input  wire logic [plcc_pkg::CH_N-1:0]             nearDropout,
	// status
	output logic                                       enabled,
	output plcc_pkg::plcc_regs_t                       regs,
	output plcc_pkg::plcc_pump_t                       pumpMode,
	// per-output controls: code, current, path select (1 = pump_output)
	output logic [plcc_pkg::CH_N-1:0][plcc_pkg::CODE_W-1:0] sinkCode,
	output logic [plcc_pkg::CH_N-1:0][plcc_pkg::CUR_W-1:0]  sinkCurrent,
	output logic [plcc_pkg::CH_N-1:0]                  usePumpOutput
);
	logic                          pinPrev_r, pinPrev_nxt;
	logic                          en_r, en_nxt;
	logic [plcc_pkg::CNT_W-1:0]    edgeCnt_r, edgeCnt_nxt;
	logic [plcc_pkg::TMR_W-1:0]    hiTmr_r, hiTmr_nxt;
	logic [plcc_pkg::TMR_W-1:0]    loTmr_r, loTmr_nxt;
	plcc_pkg::plcc_regs_t          regs_r, regs_nxt;              // two five-bit levels and the address [R4]
	logic                          setA_r, setA_nxt;              // group a written since shutdown
	logic                          set4_r, set4_nxt;              // channel four written since shutdown
	plcc_pkg::plcc_pump_t          pump_r, pump_nxt;
	logic [plcc_pkg::CH_N-1:0]     path_r, path_nxt;
	logic                          rise, latchNow, offNow;

	localparam logic [plcc_pkg::TMR_W-1:0] LATCH_LAST = plcc_pkg::TMR_W'(LATCH_CYC - 1);
	localparam logic [plcc_pkg::TMR_W-1:0] OFF_LAST   = plcc_pkg::TMR_W'(OFF_CYC - 1);

	// edge detect and timeout strobes
	assign rise     = ctrlPin && !pinPrev_r;
	assign latchNow = ctrlPin && (hiTmr_r == LATCH_LAST) && (edgeCnt_r != '0); // [R3]
	assign offNow   = !ctrlPin && (loTmr_r == OFF_LAST);

	// decoder next state
	always_comb begin
		pinPrev_nxt = ctrlPin;
		en_nxt      = en_r;
		edgeCnt_nxt = edgeCnt_r;
		regs_nxt    = regs_r;
		setA_nxt    = setA_r;
		set4_nxt    = set4_r;
		// high-time counter saturates; the edgeCnt_r != 0 term keeps one long pause to a single latch
		hiTmr_nxt   = (!ctrlPin || rise) ? '0 : ((hiTmr_r == LATCH_LAST) ? hiTmr_r : hiTmr_r + 1'b1);
		loTmr_nxt   = ctrlPin ? '0 : ((loTmr_r == OFF_LAST) ? loTmr_r : loTmr_r + 1'b1);
		if (rise) begin
			en_nxt = 1'b1; // [R12]
			if (edgeCnt_r != '1)
				edgeCnt_nxt = edgeCnt_r + 1'b1; // saturate so junk cannot wrap into a valid count
		end
		if (latchNow) begin
			edgeCnt_nxt = '0; // [R19]
			if (edgeCnt_r <= plcc_pkg::DATA_MAX) begin // [R2]
				// code 32 is stored as 5'h00 and read as full scale
				if (regs_r.addr != plcc_pkg::ADDR_CH4) begin
					regs_nxt.groupA = edgeCnt_r[plcc_pkg::CODE_W-1:0]; // [R5] [R6]
					setA_nxt        = 1'b1;
				end
				if (regs_r.addr != plcc_pkg::ADDR_GRPA) begin
					regs_nxt.chFour = edgeCnt_r[plcc_pkg::CODE_W-1:0]; // [R5] [R7]
					set4_nxt        = 1'b1;
				end
			end else if (edgeCnt_r <= plcc_pkg::EDGE_ADR2) begin
				regs_nxt.addr = 2'(edgeCnt_r - plcc_pkg::EDGE_ADR0); // [R1]
			end
			// counts above 35 leave address and levels alone [R18]
		end
		if (offNow) begin
			en_nxt          = 1'b0; // [R8]
			edgeCnt_nxt     = '0;
			regs_nxt.groupA = plcc_pkg::LEVEL_RST; // [R9]
			regs_nxt.chFour = plcc_pkg::LEVEL_RST; // [R9]
			regs_nxt.addr   = plcc_pkg::ADDR_ALL; // [R7] [R9]
			setA_nxt        = 1'b0;
			set4_nxt        = 1'b0;
		end
	end

	// decoder registers; rst stands in for the power-on shutdown state
	always_ff @(posedge clk) begin
		if (rst) begin
			pinPrev_r <= 1'b0;
			en_r      <= 1'b0;
			edgeCnt_r <= '0;
			hiTmr_r   <= '0;
			loTmr_r   <= '0;
			regs_r    <= '0;
			setA_r    <= 1'b0;
			set4_r    <= 1'b0;
		end else begin
			pinPrev_r <= pinPrev_nxt;
			en_r      <= en_nxt;
			edgeCnt_r <= edgeCnt_nxt;
			hiTmr_r   <= hiTmr_nxt;
			loTmr_r   <= loTmr_nxt;
			regs_r    <= regs_nxt;
			setA_r    <= setA_nxt;
			set4_r    <= set4_nxt;
		end
	end

	// pump ratio: off, start at 1.5x, step to 2x on renewed dropout
	always_comb begin
		pump_nxt = pump_r;
		if (!en_r) begin
			pump_nxt = plcc_pkg::PUMP_OFF; // [R8]
		end else begin
			unique case (pump_r)
				plcc_pkg::PUMP_OFF: if (|nearDropout) pump_nxt = plcc_pkg::PUMP_X15; // [R13]
				plcc_pkg::PUMP_X15: if (|(nearDropout & path_r)) pump_nxt = plcc_pkg::PUMP_X2; // [R14]
				plcc_pkg::PUMP_X2:  pump_nxt = plcc_pkg::PUMP_X2; // stays until shutdown, no hysteresis info
				default:            pump_nxt = plcc_pkg::PUMP_OFF;
			endcase
		end
	end

	// per-output path: once an output nears dropout on the direct path it moves to the pump
	always_comb begin
		path_nxt = path_r;
		if (!en_r)
			path_nxt = '0;
		else
			path_nxt = path_r | nearDropout; // [R15]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pump_r <= plcc_pkg::PUMP_OFF;
			path_r <= '0;
		end else begin
			pump_r <= pump_nxt;
			path_r <= path_nxt;
		end
	end

	// per-channel codes and current lookup; outputs one to three share group a
	for (genvar ch = 0; ch < plcc_pkg::CH_N; ch++) begin : gChan
		logic [plcc_pkg::CODE_W-1:0] chCode;
		logic [plcc_pkg::CUR_W-1:0]  chCur;
		assign chCode = (ch == plcc_pkg::CH_N - 1) ? regs_r.chFour : regs_r.groupA; // [R12]
		plcc_level_rom uRom (
			.clk     (clk),
			.rst     (rst),
			.code    (chCode),
			.current (chCur)
		);
		assign sinkCode[ch]    = chCode;
		// a written flag tells code 32 (stored as zero) from a cleared level [R8] [R11]
		assign sinkCurrent[ch] = (en_r && ((ch == plcc_pkg::CH_N - 1) ? set4_r : setA_r)) ? chCur : '0;
		assign usePumpOutput[ch] = path_r[ch] && (pump_r != plcc_pkg::PUMP_OFF);
	end

	assign enabled  = en_r;
	assign regs     = regs_r;
	assign pumpMode = pump_r;
endmodule

// file: verilog/plcc_level_rom.sv
// code to current lookup, registered output
// assumes code is the 5-bit stored brightness code; 0 (code 32) gives the full-scale current
module plcc_level_rom (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// lookup
	input  wire logic [plcc_pkg::CODE_W-1:0]   code,
	output logic      [plcc_pkg::CUR_W-1:0]    current
);
	logic [plcc_pkg::CUR_W-1:0] table_c;
	logic [plcc_pkg::CUR_W-1:0] current_nxt;

	// code 32 wraps to 0 in five bits, so index 0 is the full-scale entry [R11]
	always_comb begin
		unique case (code)
			5'h00: table_c = 9'h12C; 5'h01: table_c = 9'h000; 5'h02: table_c = 9'h001;
			5'h03: table_c = 9'h002; 5'h04: table_c = 9'h004; 5'h05: table_c = 9'h005;
			5'h06: table_c = 9'h007; 5'h07: table_c = 9'h00B; 5'h08: table_c = 9'h012;
			5'h09: table_c = 9'h014; 5'h0A: table_c = 9'h016; 5'h0B: table_c = 9'h019;
			5'h0C: table_c = 9'h01C; 5'h0D: table_c = 9'h020; 5'h0E: table_c = 9'h023;
			5'h0F: table_c = 9'h028; 5'h10: table_c = 9'h02D; 5'h11: table_c = 9'h033;
			5'h12: table_c = 9'h038; 5'h13: table_c = 9'h03C; 5'h14: table_c = 9'h046;
			5'h15: table_c = 9'h050; 5'h16: table_c = 9'h05A; 5'h17: table_c = 9'h064;
			5'h18: table_c = 9'h078; 5'h19: table_c = 9'h082; 5'h1A: table_c = 9'h096;
			5'h1B: table_c = 9'h0AA; 5'h1C: table_c = 9'h0BE; 5'h1D: table_c = 9'h0D2;
			5'h1E: table_c = 9'h0F0; 5'h1F: table_c = 9'h10E;
			default: table_c = 9'h000;
		endcase
	end

	always_comb begin
		current_nxt = table_c;
	end

	always_ff @(posedge clk) begin
		if (rst) current <= '0;
		else     current <= current_nxt;
	end
endmodule

// file: verilog/plcc_pkg.sv
// package for the single-wire pulse-count led current controller
// assumes one 100 MHz clock, synchronous active-high reset, control pin already synchronous
// What this block does
// (R1) burst of 33, 34, 35 rising edges selects address 0, 1, 2
// (R2) burst of 1 to 32 edges loads that count as brightness code
// (R3) count is latched only after pin stays high for the latch timeout
// (R4) two brightness registers, five bits each
// (R5) address 0 writes both, 1 writes group a, 2 writes channel four
// (R6) latched address stays selected across many data bursts
// (R7) after disable the address is 0, so bare data loads both registers
// (R8) pin low beyond off timeout enters shutdown, outputs and pump off
// (R9) shutdown clears both brightness registers and the address
// (R10) host sends address, latch pause, data, latch pause
// (R11) codes map to current on a log scale, code 32 is 30 mA
// (R12) pulses enable the device; latched codes set each channel current
// (R13) pump starts at 1.5x when any output nears dropout
// (R14) at 1.5x, renewed dropout on any output moves pump to 2x
// (R15) each output picks direct supply or pump output from its own sense
// (R16) host high pulses are at least 50 ns
// (R17) host high pulses are at most 75 us
// (R18) latched count above 35 is ignored
// (R19) edge counter clears after each latch
package plcc_pkg;
	localparam int CLK_MHZ          = 100;
	localparam int LATCH_US         = 500;                   // latch_timeout
	localparam int OFF_US           = 500;                   // off timeout
	localparam int LATCH_CYC        = LATCH_US * CLK_MHZ;
	localparam int OFF_CYC          = OFF_US * CLK_MHZ;
	localparam int CODE_W           = 5;
	localparam int CNT_W            = 6;
	localparam int TMR_W            = 17;
	localparam int CH_N             = 4;
	localparam int CUR_W            = 9;                     // current in 0.1 mA units
	localparam logic [1:0] ADDR_ALL = 2'h0;                  // all_channels_level
	localparam logic [1:0] ADDR_GRPA = 2'h1;                 // group_a_level
	localparam logic [1:0] ADDR_CH4 = 2'h2;                  // channel_four_level
	localparam logic [CNT_W-1:0] DATA_MAX  = 6'h20;
	localparam logic [CNT_W-1:0] EDGE_ADR0 = 6'h21;
	localparam logic [CNT_W-1:0] EDGE_ADR2 = 6'h23;
	localparam logic [CODE_W-1:0] LEVEL_RST = 5'h00;

	typedef enum logic [1:0] {PUMP_OFF, PUMP_X15, PUMP_X2} plcc_pump_t;

	typedef struct packed {
		logic [CODE_W-1:0] groupA;
		logic [CODE_W-1:0] chFour;
		logic [1:0]        addr;
	} plcc_regs_t;
endpackage
